// ### hw/apss_pkg.sv
package apss_pkg;
  // channel count and aux line count
  localparam int APSS_NUM_MOTORS = 3;
  localparam int APSS_NUM_AUX = 2;
  // clock rate
  localparam longint APSS_CLK_HZ = 10_000_000;
  // fixed pause between interval cycles, in milliseconds
  localparam longint APSS_LOOP_PAUSE_MS = 100;
  localparam longint APSS_LOOP_PAUSE_CYC = (APSS_LOOP_PAUSE_MS * APSS_CLK_HZ) / 1000;
  // debounce settle time, in milliseconds
  localparam longint APSS_DEBOUNCE_MS = 10;
  localparam longint APSS_DEBOUNCE_CYC = (APSS_DEBOUNCE_MS * APSS_CLK_HZ) / 1000;
  // triple click window, in milliseconds
  localparam longint APSS_CLICK_WIN_MS = 1500;
  localparam longint APSS_CLICK_WIN_CYC = (APSS_CLICK_WIN_MS * APSS_CLK_HZ) / 1000;
  // millisecond tick divider
  localparam longint APSS_MS_CYC = APSS_CLK_HZ / 1000;
  localparam int APSS_TIME_W = 24;
  localparam int APSS_MS_DIV_W = 14;
  localparam int APSS_CLICKS_TO_TOGGLE = 3;
  // reset values
  localparam logic APSS_FOCUS_WITH_SHUTTER_RST = 1'b1;
  localparam logic [APSS_NUM_MOTORS-1:0] APSS_POWER_SAVE_RST = 3'h0;
  // sequencer states
  typedef enum logic [2:0] {
    APSS_IDLE,
    APSS_FOCUS,
    APSS_TRIGGER,
    APSS_MOTOR_DELAY,
    APSS_MOVE,
    APSS_BUFFER,
    APSS_PAUSE,
    APSS_WAIT_AUX
  } apss_state_t;
endpackage

// ### hw/apss_debounce.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================
// debounce filter
module apss_debounce #(
  parameter int SETTLE_CYC = 100000,
  parameter int CNT_W = 20
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // raw level and filtered level
  input wire logic raw_i,
  output logic clean_o
);
  logic [CNT_W-1:0] count;
  // output follows the raw level only after it stays put for the settle time
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count <= '0;
      clean_o <= 1'b0;
    end
    else if (raw_i == clean_o)
    begin
      count <= '0;
    end
    else if (count == CNT_W'(SETTLE_CYC - 1))
    begin
      count <= '0;
      clean_o <= raw_i;
    end
    else
    begin
      count <= count + 1'b1;
    end
  end
endmodule // apss_debounce
`default_nettype wire

// ### hw/apss_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - bracketed exposure: hold shutter for trigger time, then exposure delay before motion.
// - focus may be held for the whole shutter assertion; option on after reset.
// - focus-with-shutter defaults enabled; focus accompanies shutter unless turned off.
// - three emergency-stop clicks after boot toggle externally paced mode.
// - rightmost network port indicator lit exactly while paced mode is active.
// - in paced mode, move spacing comes from the aux input, not the interval timer.
// - in paced mode, a cycle starts at focus on the deasserting edge of the aux input.
// - after start in paced mode, hold position until an external signal arrives.
// - an aux trigger can fire the camera and then perform the following move.
// - two aux lines idle high; a line grounded low counts as asserted.
// - up to three stepper channels driven simultaneously, each through its own driver.
// - power saving is off for every motor port after reset.
// - with power saving on, a driver is enabled only while its port moves.
// - each motor port keeps its own independent power-saving setting.
// - power saving on an idle port disables its driver and light at once.
// - cycle order: focus, trigger, motor delay, move, then buffer except in paced mode; starts at start or aux.
// - a fixed pause separates the end of one cycle from the next start.
module apss_sequencer
  import apss_pkg::*;
#(
  parameter int LOOP_PAUSE_CYC = int'(apss_pkg::APSS_LOOP_PAUSE_CYC),
  parameter int DEBOUNCE_CYC = int'(apss_pkg::APSS_DEBOUNCE_CYC),
  parameter int CLICK_WIN_CYC = int'(apss_pkg::APSS_CLICK_WIN_CYC),
  parameter int MS_CYC = int'(apss_pkg::APSS_MS_CYC)
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // program control
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic estop_button_n_i,
  // timing settings in milliseconds
  input wire logic [apss_pkg::APSS_TIME_W-1:0] focus_ms_i,
  input wire logic [apss_pkg::APSS_TIME_W-1:0] trigger_ms_i,
  input wire logic [apss_pkg::APSS_TIME_W-1:0] motor_delay_ms_i,
  input wire logic [apss_pkg::APSS_TIME_W-1:0] interval_ms_i,
  // options
  input wire logic focus_with_shutter_off_i,
  input wire logic [apss_pkg::APSS_NUM_MOTORS-1:0] power_save_i,
  input wire logic [apss_pkg::APSS_NUM_MOTORS-1:0] motor_used_i,
  // motion engine handshake
  output logic [apss_pkg::APSS_NUM_MOTORS-1:0] move_start_o,
  input wire logic [apss_pkg::APSS_NUM_MOTORS-1:0] move_busy_i,
  // aux port, active low lines
  input wire logic [apss_pkg::APSS_NUM_AUX-1:0] aux_n_i,
  // camera lines
  output logic focus_o,
  output logic shutter_o,
  // drivers and lights
  output logic [apss_pkg::APSS_NUM_MOTORS-1:0] driver_enable_o,
  output logic [apss_pkg::APSS_NUM_MOTORS-1:0] motor_light_o,
  output logic paced_light_o,
  output logic paced_mode_o,
  output logic running_o
);
  import apss_pkg::*;

  // =====================================
  // input conditioning
  logic estop_pressed;
  logic [APSS_NUM_AUX-1:0] aux_asserted;

  apss_debounce #(.SETTLE_CYC(DEBOUNCE_CYC), .CNT_W(24)) u_db_estop (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .raw_i(~estop_button_n_i),
    .clean_o(estop_pressed)
  );

  genvar g;
  generate
    for (g = 0; g < APSS_NUM_AUX; g++)
    begin : g_aux
      // grounded line means asserted
      apss_debounce #(.SETTLE_CYC(DEBOUNCE_CYC), .CNT_W(24)) u_db_aux (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .raw_i(~aux_n_i[g]),
        .clean_o(aux_asserted[g])
      );
    end
  endgenerate

  // either aux line counts as the trigger
  logic aux_any;
  logic aux_any_d;
  logic estop_d;
  logic aux_fall;
  logic click;
  assign aux_any = |aux_asserted;
  assign aux_fall = aux_any_d & ~aux_any;
  assign click = estop_pressed & ~estop_d;

  // edge detect registers
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      aux_any_d <= 1'b0;
      estop_d <= 1'b0;
    end
    else
    begin
      aux_any_d <= aux_any;
      estop_d <= estop_pressed;
    end
  end

  // =====================================
  // triple click toggles paced mode
  logic [1:0] click_count;
  logic [23:0] click_timer;
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      click_count <= '0;
      click_timer <= '0;
      paced_mode_o <= 1'b0;
      paced_light_o <= 1'b0;
    end
    else
    begin
      if (click)
      begin
        if (click_count == 2'(APSS_CLICKS_TO_TOGGLE - 1))
        begin
          click_count <= '0;
          paced_mode_o <= ~paced_mode_o;
          paced_light_o <= ~paced_mode_o;
        end
        else
        begin
          if (click_count == '0)
            click_timer <= 24'(CLICK_WIN_CYC);
          click_count <= click_count + 1'b1;
        end
      end
      else if (click_count != '0)
      begin
        // stale clicks are dropped when the window runs out
        if (click_timer == '0)
          click_count <= '0;
        else
          click_timer <= click_timer - 1'b1;
      end
    end
  end

  // =====================================
  // millisecond tick, restarted at each state change for exact phase lengths
  logic [APSS_MS_DIV_W-1:0] ms_div;
  logic ms_tick;
  logic phase_load;
  assign ms_tick = (ms_div == APSS_MS_DIV_W'(MS_CYC - 1));

  // =====================================
  // interval sequencer
  apss_state_t state;
  apss_state_t next_state;
  logic [APSS_TIME_W-1:0] phase_ms;
  logic [APSS_TIME_W-1:0] elapsed_ms;
  logic [APSS_TIME_W-1:0] next_phase_ms;
  logic [23:0] pause_cnt;
  logic move_issued;

  function automatic logic time_done(input logic [APSS_TIME_W-1:0] t,
                                     input logic [APSS_TIME_W-1:0] lim);
    time_done = (t >= lim);
  endfunction

  // next-state decode
  always_comb
  begin
    next_state = state;
    next_phase_ms = '0;
    unique case (state)
      APSS_IDLE:
        if (start_i)
          next_state = paced_mode_o ? APSS_WAIT_AUX : APSS_FOCUS;
      APSS_WAIT_AUX:
        if (aux_fall)
          next_state = APSS_FOCUS;
      APSS_FOCUS:
        if (time_done(phase_ms, focus_ms_i))
          next_state = APSS_TRIGGER;
      APSS_TRIGGER:
        if (time_done(phase_ms, trigger_ms_i))
          next_state = APSS_MOTOR_DELAY;
      APSS_MOTOR_DELAY:
        if (time_done(phase_ms, motor_delay_ms_i))
          next_state = APSS_MOVE;
      APSS_MOVE:
        if (move_issued && (move_busy_i == '0))
          next_state = paced_mode_o ? APSS_PAUSE : APSS_BUFFER;
      APSS_BUFFER:
        if (time_done(elapsed_ms, interval_ms_i))
          next_state = APSS_PAUSE;
      APSS_PAUSE:
        if (pause_cnt == '0)
          next_state = paced_mode_o ? APSS_WAIT_AUX : APSS_FOCUS;
    endcase
    if (stop_i)
      next_state = APSS_IDLE;
  end
  assign phase_load = (next_state != state);

  // state, phase and interval timers
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= APSS_IDLE;
      ms_div <= '0;
      phase_ms <= '0;
      elapsed_ms <= '0;
      pause_cnt <= '0;
      move_issued <= 1'b0;
      running_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      running_o <= (next_state != APSS_IDLE);
      ms_div <= (phase_load || ms_tick) ? '0 : ms_div + 1'b1;
      if (phase_load)
        phase_ms <= next_phase_ms;
      else if (ms_tick)
        phase_ms <= phase_ms + 1'b1;
      // interval runs from focus start through buffer
      if (phase_load && next_state == APSS_FOCUS)
        elapsed_ms <= '0;
      else if (ms_tick)
        elapsed_ms <= elapsed_ms + 1'b1;
      if (phase_load && next_state == APSS_PAUSE)
        pause_cnt <= 24'(LOOP_PAUSE_CYC - 1);
      else if (pause_cnt != '0)
        pause_cnt <= pause_cnt - 1'b1;
      move_issued <= (state == APSS_MOVE) && !phase_load;
    end
  end

  // =====================================
  // camera lines; focus option is on after reset
  logic focus_with_shutter;
  assign focus_with_shutter = APSS_FOCUS_WITH_SHUTTER_RST & ~focus_with_shutter_off_i;
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      focus_o <= 1'b0;
      shutter_o <= 1'b0;
    end
    else
    begin
      shutter_o <= (next_state == APSS_TRIGGER);
      focus_o <= (next_state == APSS_FOCUS) ||
                 (focus_with_shutter && next_state == APSS_TRIGGER);
    end
  end

  // =====================================
  // motor channels: one start pulse to every used channel at once
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      move_start_o <= '0;
    else
      move_start_o <= (phase_load && next_state == APSS_MOVE) ? motor_used_i : '0;
  end

  // drivers stay energised unless that port's own power save is on and it is idle;
  // the driver comes up with the start pulse and the pulse itself keeps it up
  // for the one cycle before busy is seen, so the driver never blinks off mid-start
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      driver_enable_o <= ~APSS_POWER_SAVE_RST;
      motor_light_o <= ~APSS_POWER_SAVE_RST;
    end
    else
    begin
      for (int m = 0; m < APSS_NUM_MOTORS; m++)
      begin
        driver_enable_o[m] <= ~power_save_i[m] | move_busy_i[m] | move_start_o[m] |
                              (phase_load && next_state == APSS_MOVE && motor_used_i[m]);
        motor_light_o[m] <= ~power_save_i[m] | move_busy_i[m];
      end
    end
  end
endmodule // apss_sequencer
`default_nettype wire

// ### bench/apss_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module apss_monitor
  import apss_pkg::*;
#(
  parameter int LOOP_PAUSE_CYC = int'(APSS_LOOP_PAUSE_CYC)
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // inputs
  input wire logic focus_with_shutter_off_i,
  input wire logic [APSS_NUM_MOTORS-1:0] power_save_i,
  input wire logic [APSS_NUM_MOTORS-1:0] motor_used_i,
  input wire logic [APSS_NUM_MOTORS-1:0] move_busy_i,
  input wire logic [APSS_NUM_AUX-1:0] aux_n_i,
  input wire logic [APSS_TIME_W-1:0] motor_delay_ms_i,
  // outputs
  input wire logic [APSS_NUM_MOTORS-1:0] move_start_o,
  input wire logic [APSS_NUM_MOTORS-1:0] driver_enable_o,
  input wire logic [APSS_NUM_MOTORS-1:0] motor_light_o,
  input wire logic focus_o,
  input wire logic shutter_o,
  input wire logic paced_light_o,
  input wire logic paced_mode_o,
  input wire logic running_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [23:0] gap;
  // idle cycles since motion inside one run; saturates so long waits never wrap,
  // and a stopped program starts afresh since a stop is no cycle boundary
  always_ff @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
      gap <= '1;
    else if (!running_o)
      gap <= '1;
    else if (|move_busy_i)
      gap <= '0;
    else if (gap != '1)
      gap <= gap + 24'h1;
  focus_hold_a: assert property (shutter_o && !focus_with_shutter_off_i |-> focus_o)
    else $error("focus low while shutter held");
  paced_lamp_a: assert property (paced_light_o == paced_mode_o)
    else $error("paced light differs from mode");
  still_expose_a: assert property (|move_start_o |-> !shutter_o && !$past(shutter_o))
    else $error("move during shutter");
  exp_delay_a: assert property ($fell(shutter_o) && motor_delay_ms_i != '0 |->
    (move_start_o == 3'h0) [*8])
    else $error("move inside exposure delay");
  aux_release_a: assert property ($rose(shutter_o) && paced_mode_o |->
    &$past(aux_n_i, 4))
    else $error("paced shot without aux release");
  drv_save_a: assert property (!$past(reset_i) |->
    ((driver_enable_o ^ ~$past(power_save_i))
    & ~($past(move_busy_i | move_start_o) | move_start_o)) == 3'h0)
    else $error("driver enable wrong");
  lamp_save_a: assert property (!$past(reset_i) |->
    ((motor_light_o ^ ~$past(power_save_i)) & ~$past(move_busy_i)) == 3'h0)
    else $error("motor light wrong");
  used_only_a: assert property ((move_start_o & ~motor_used_i) == 3'h0)
    else $error("move on unused channel");
  pause_gap_a: assert property ($rose(shutter_o) |-> gap >= 24'(LOOP_PAUSE_CYC - 1))
    else $error("cycle pause too short");
  cover property ($rose(paced_mode_o));
  cover property (|move_start_o);
  cover property (shutter_o && !focus_o);
endmodule // apss_monitor
bind apss_sequencer apss_monitor #(.LOOP_PAUSE_CYC(LOOP_PAUSE_CYC)) u_mon (.core_clk_i,
  .reset_i, .focus_with_shutter_off_i, .power_save_i, .motor_used_i, .move_busy_i, .aux_n_i,
  .motor_delay_ms_i, .move_start_o, .driver_enable_o, .motor_light_o, .focus_o, .shutter_o,
  .paced_light_o, .paced_mode_o, .running_o);
`default_nettype wire

// ### bench/apss_motion_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// motion engine stand-in
module apss_motion_model
  import apss_pkg::*;
#(
  parameter int BUSY_CYC = 3
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // move handshake
  input wire logic [APSS_NUM_MOTORS-1:0] move_start_i,
  output logic [APSS_NUM_MOTORS-1:0] move_busy_o
);
  int left [APSS_NUM_MOTORS];
  // channel m runs BUSY_CYC << m, so quick and slow moves overlap
  always_ff @(posedge core_clk_i or posedge reset_i)
    for (int m = 0; m < APSS_NUM_MOTORS; m++)
      if (reset_i)
        left[m] <= 0;
      else if (move_start_i[m])
        left[m] <= BUSY_CYC << m;
      else if (left[m] > 0)
        left[m] <= left[m] - 1;
  always_comb
    for (int m = 0; m < APSS_NUM_MOTORS; m++)
      move_busy_o[m] = (left[m] != 0);
endmodule // apss_motion_model
`default_nettype wire

// ### bench/apss_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// sequencer bench
module apss_sequencer_tb;
  import apss_pkg::*;
  logic clk, rst, start, stop, est_n, fws_off, focus, shutter, pled, paced, running;
  logic [2:0] ps, used, mst, busy, drv, mlt;
  logic [1:0] aux_n;
  logic [APSS_TIME_W-1:0] fms, tms, dms, ims;
  int err_count = 0;
  int n_compared = 0;
  int n;
  int k;
  apss_sequencer #(.LOOP_PAUSE_CYC(50), .DEBOUNCE_CYC(4), .CLICK_WIN_CYC(200), .MS_CYC(10)) uut (
    .core_clk_i(clk), .reset_i(rst), .start_i(start), .stop_i(stop), .estop_button_n_i(est_n),
    .focus_ms_i(fms), .trigger_ms_i(tms), .motor_delay_ms_i(dms), .interval_ms_i(ims),
    .focus_with_shutter_off_i(fws_off), .power_save_i(ps), .motor_used_i(used),
    .move_start_o(mst), .move_busy_i(busy), .aux_n_i(aux_n), .focus_o(focus),
    .shutter_o(shutter), .driver_enable_o(drv), .motor_light_o(mlt), .paced_light_o(pled),
    .paced_mode_o(paced), .running_o(running));
  apss_motion_model u_mot (.core_clk_i(clk), .reset_i(rst), .move_start_i(mst),
    .move_busy_o(busy));
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 3000 && s !== 1'b1; i++) step(1);
    chk(s, 1);
  endtask
  task automatic go();
    start = 1;
    step(1);
    start = 0;
  endtask
  // stop, then let the pause drain so the next run starts clean
  task automatic halt();
    stop = 1;
    step(1);
    stop = 0;
    step(60);
  endtask
  task automatic click();
    est_n = 0;
    step(8);
    est_n = 1;
    step(8);
  endtask
  task automatic t_shot();
    go();
    wait_hi(focus);
    chk(shutter, 0);
    wait_hi(shutter);
    chk(focus, 1);
    for (n = 0; shutter === 1'b1 && n < 99; n++) step(1);
    chk(n >= 20 && n <= 32, 1);
    for (n = 0; mst === 3'h0 && n < 99; n++) step(1);
    chk(n >= 9, 1);
    chk(mst, 3'h7);
    halt();
    fws_off = 1;
    fms = 0;
    go();
    wait_hi(shutter);
    chk(focus, 0);
    halt();
    fws_off = 0;
    fms = 1;
    $display("shot test done");
  endtask
  task automatic t_psave();
    ps = 3'h2;
    step(3);
    chk({drv, mlt}, 6'h2d);
    used = 3'h2;
    go();
    for (n = 0; busy[1] !== 1'b1 && n < 999; n++) step(1);
    chk(drv, 3'h7);
    step(9);
    chk({drv, mlt}, 6'h2d);
    // the loop goes on by itself: buffer, then the fixed pause before the next focus
    for (n = 0; focus !== 1'b1 && n < 200; n++) step(1);
    chk(n >= 45 && n <= 55, 1);
    halt();
    ps = 3'h0;
    used = 3'h7;
    $display("power save test done");
  endtask
  task automatic t_paced();
    click();
    step(250);
    click();
    click();
    chk(paced, 0);
    step(250);
    repeat (3) click();
    chk({paced, pled}, 2'h3);
    go();
    step(300);
    chk({focus, shutter, running}, 3'h1);
    aux_n = 2'h1;
    step(20);
    chk({focus, shutter}, 0);
    aux_n = 2'h3;
    wait_hi(shutter);
    // no further shot may follow without a new aux release
    for (n = 0; shutter === 1'b1 && n < 99; n++) step(1);
    k = 0;
    repeat (200)
    begin
      step(1);
      if (shutter !== 1'b0)
        k++;
    end
    chk(k, 0);
    aux_n = 2'h2;
    step(10);
    aux_n = 2'h3;
    wait_hi(shutter);
    halt();
    repeat (3) click();
    chk({paced, pled}, 2'h0);
    $display("paced test done");
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: the tests need under 5000 cycles
  initial
  begin
    #2000000;
    err_count++;
    end_of_test();
  end
  initial
  begin
    rst = 1;
    {start, stop, fws_off} = 3'h0;
    est_n = 1;
    ps = 3'h0;
    used = 3'h7;
    aux_n = 2'h3;
    {fms, tms, dms, ims} = {24'h1, 24'h2, 24'h1, 24'h0};
    repeat (6) @(posedge clk);
    #1;
    rst = 0;
    chk({drv, mlt, paced, pled, focus, shutter, running}, 11'h7e0);
    t_shot();
    t_psave();
    t_paced();
    end_of_test();
  end
endmodule // apss_sequencer_tb
`default_nettype wire
